// ### rtl/cmp_ctl_pkg.sv
package cmp_ctl_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [15:0] OFS_STATUS = 16'h0094;
	localparam logic [15:0] OFS_CFG_AB = 16'ha030;
	localparam logic [15:0] OFS_CFG_CD = 16'ha031;
	localparam logic [15:0] OFS_THRESHOLD_LEVEL_ZERO = 16'ha032;
	localparam logic [15:0] OFS_THRESHOLD_LEVEL_ONE = 16'ha033;
	localparam logic [15:0] OFS_IRQ_MASK = 16'ha034;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_NIB = 4'h0;
	localparam logic [1:0] RST_HYS = 2'h0;
	// ------------------------------------------------------------
	// field layout of one channel nibble in the config registers
	// ------------------------------------------------------------
	localparam int NCH = 4;
	localparam int F_ON = 3;
	localparam int F_PICK = 2;
	localparam int F_IRQ = 1;
	localparam int F_INV = 0;
	localparam int NIB_W = 4;
	// status register layout
	localparam int ST_LIVE_LO = 0;
	localparam int ST_PEND_LO = 4;
	localparam int HYS_A_LO = 0;
	localparam int HYS_BCD_LO = 2;
	// hysteresis codes
	typedef enum logic [1:0] {
		HYS_OFF = 2'b00,
		HYS_10MV = 2'b01,
		HYS_20MV = 2'b10,
		HYS_30MV = 2'b11
	} hys_t;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int SETTLE_US = 20;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
endpackage

// ### rtl/cmp_pin_sync.sv
`timescale 1ns/1ps
module cmp_pin_sync
	import cmp_ctl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic [NCH-1:0] i_raw,
	output logic [NCH-1:0] o_sync
);
	typedef struct packed {
		logic [NCH-1:0] s1;
		logic [NCH-1:0] s2;
	} sync_t;
	sync_t q, d;
	always_comb begin
		d = q;
		if (i_ce) begin
			d.s1 = i_raw;
			d.s2 = q.s1;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_sync = q.s2;
endmodule

// ### rtl/cmp_edge_chan.sv
`timescale 1ns/1ps
module cmp_edge_chan
	import cmp_ctl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_on,
	input wire logic i_invert,
	input wire logic i_raw,
	output logic o_live,
	output logic o_toggle
);
	typedef struct packed {
		logic live;
	} edge_t;
	edge_t q, d;
	logic cur;
	// polarity applied before status and edge detection
	assign cur = i_on & (i_raw ^ i_invert); // R5 R7
	always_comb begin
		d = q;
		if (i_ce) begin
			d.live = cur;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_live = q.live;
	// both directions count
	assign o_toggle = i_ce & i_on & (cur != q.live); // R10
endmodule

// ### rtl/quad_comparator_control.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// R1: four channels, each has an on bit; clearing it turns the channel off
// R2: software waits 20us after enabling before trusting output or flags
// R3: channel A pick bit chooses threshold level zero or level one
// R4: channels B-D pick bit chooses level zero or external threshold pin
// R5: per-channel invert bit flips result before status and edge detect
// R6: per-channel irq allow bit lets its pending flag request interrupt
// R7: status bits 3..0 show live outputs, zero when channel is off
// R8: pending flags in bits 7..4 set on each live toggle while enabled
// R9: pending flags stay set until software clears them by a write
// R10: edge detector catches both rising and falling transitions
// R11: channel A hysteresis code 00 off, 01 10mV, 10 20mV
// R12: shared B-D hysteresis code 00 off, 01 10mV, 10 20mV
// R13: two threshold registers hold 8-bit ladder DAC codes
// R14: software should park unused threshold registers at 0x00
// R15: pins need analog connect set and digital drivers off
// R16: hysteresis code 11 selects 30mV
// R17: status low-bit writes load hysteresis; writing zero clears a flag
module quad_comparator_control
	import cmp_ctl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [NCH-1:0] i_cmp_raw,
	output logic [NCH-1:0] o_cmp_on,
	output logic [NCH-1:0] o_cmp_thresh_pick,
	output logic [7:0] o_threshold_level_zero,
	output logic [7:0] o_threshold_level_one,
	output hys_t o_chan_a_hysteresis,
	output hys_t o_chan_bcd_hysteresis,
	output logic [NCH-1:0] o_cmp_settled,
	output logic o_irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfg_ab;
		logic [7:0] cfg_cd;
		logic [7:0] threshold_level_zero;
		logic [7:0] threshold_level_one;
		logic [NCH-1:0] pending;
		logic [NCH-1:0] irq_mask;
		logic [1:0] hys_a;
		logic [1:0] hys_bcd;
		logic [7:0] rdata;
	} regs_t;
	regs_t q, d;

	logic [NCH-1:0] raw_s;
	logic [NCH-1:0] live;
	logic [NCH-1:0] toggle;
	logic [NCH-1:0] on_v;
	logic [NCH-1:0] pick_v;
	logic [NCH-1:0] allow_v;
	logic [NCH-1:0] inv_v;
	logic [NCH-1:0] settled;

	// ------------------------------------------------------------
	// per-channel fields: A,B in cfg_ab high/low, C,D in cfg_cd
	// ------------------------------------------------------------
	// settle counter wide enough to hold the full settle count
	localparam int CNT_W = $clog2(SETTLE_CYC + 1);
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [NIB_W-1:0] nib;
			logic [CNT_W-1:0] cnt_q;
			if (g < 2) begin : g_ab
				assign nib = q.cfg_ab[(1-g)*NIB_W +: NIB_W];
			end else begin : g_cd
				assign nib = q.cfg_cd[(3-g)*NIB_W +: NIB_W];
			end
			assign on_v[g] = nib[F_ON]; // R1
			assign pick_v[g] = nib[F_PICK]; // R3 R4
			assign allow_v[g] = nib[F_IRQ];
			assign inv_v[g] = nib[F_INV];
			cmp_edge_chan u_edge (
				.i_clk_sys(i_clk_sys),
				.i_sys_rst(i_sys_rst),
				.i_ce(i_ce),
				.i_on(on_v[g]),
				.i_invert(inv_v[g]),
				.i_raw(raw_s[g]),
				.o_live(live[g]),
				.o_toggle(toggle[g])
			);
			// settle indicator for software's wait after enabling
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					cnt_q <= '0;
				end else if (i_ce) begin
					if (!on_v[g]) begin
						cnt_q <= '0;
					end else if (cnt_q != CNT_W'(SETTLE_CYC)) begin
						cnt_q <= cnt_q + CNT_W'(1);
					end
				end
			end
			assign settled[g] = (cnt_q == CNT_W'(SETTLE_CYC)); // R2
		end
	endgenerate

	cmp_pin_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_raw(i_cmp_raw),
		.o_sync(raw_s)
	);

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic wr_st;
	assign wr_st = i_wr & (i_addr == OFS_STATUS);

	always_comb begin
		d = q;
		if (i_ce) begin
			if (i_wr) begin
				unique case (i_addr)
					OFS_CFG_AB: d.cfg_ab = i_wdata; // R1
					OFS_CFG_CD: d.cfg_cd = i_wdata;
					OFS_THRESHOLD_LEVEL_ZERO: d.threshold_level_zero = i_wdata; // R13
					OFS_THRESHOLD_LEVEL_ONE: d.threshold_level_one = i_wdata; // R13
					OFS_IRQ_MASK: d.irq_mask = i_wdata[NCH-1:0];
					OFS_STATUS: begin
						d.hys_a = i_wdata[HYS_A_LO +: 2]; // R11 R17
						d.hys_bcd = i_wdata[HYS_BCD_LO +: 2]; // R12 R17
					end
					default: begin
					end
				endcase
			end
			// zero written to a flag clears it; a new toggle wins
			if (wr_st) begin
				d.pending = q.pending & i_wdata[ST_PEND_LO +: NCH]; // R9 R17
			end
			d.pending = d.pending | toggle; // R8
			d.rdata = RST_BYTE;
			if (i_rd) begin
				unique case (i_addr)
					OFS_CFG_AB: d.rdata = q.cfg_ab;
					OFS_CFG_CD: d.rdata = q.cfg_cd;
					OFS_THRESHOLD_LEVEL_ZERO: d.rdata = q.threshold_level_zero;
					OFS_THRESHOLD_LEVEL_ONE: d.rdata = q.threshold_level_one;
					OFS_IRQ_MASK: d.rdata = {4'h0, q.irq_mask};
					OFS_STATUS: d.rdata = {q.pending, live}; // R7
					default: d.rdata = RST_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_rdata = q.rdata;
	assign o_cmp_on = on_v;
	assign o_cmp_thresh_pick = pick_v;
	assign o_threshold_level_zero = q.threshold_level_zero;
	assign o_threshold_level_one = q.threshold_level_one;
	assign o_chan_a_hysteresis = hys_t'(q.hys_a); // R11 R16
	assign o_chan_bcd_hysteresis = hys_t'(q.hys_bcd); // R12 R16
	assign o_cmp_settled = settled;
	assign o_irq = |(q.pending & allow_v & q.irq_mask); // R6

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_off_live_zero: assert property (@(posedge i_clk_sys) // R7
		disable iff (i_sys_rst) !on_v[0] ##1 !on_v[0] |-> !live[0])
		else $error("live output set on disabled channel");
	a_toggle_sets_flag: assert property (@(posedge i_clk_sys) // R8
		disable iff (i_sys_rst) toggle[1] |=> q.pending[1])
		else $error("toggle did not set pending");
	a_flag_sticky: assert property (@(posedge i_clk_sys) // R9
		disable iff (i_sys_rst) q.pending[2] && !wr_st |=> q.pending[2])
		else $error("pending cleared without a write");
	a_irq_gate: assert property (@(posedge i_clk_sys) // R6
		disable iff (i_sys_rst)
		(q.pending[0] && allow_v[0] && q.irq_mask[0]) |-> o_irq)
		else $error("enabled pending did not raise irq");
	a_edge_both: assert property (@(posedge i_clk_sys) // R10
		disable iff (i_sys_rst)
		i_ce && on_v[3] && $stable(on_v[3]) && $stable(inv_v[3])
		&& $changed(raw_s[3]) |-> toggle[3])
		else $error("edge missed");
	a_hys_load: assert property (@(posedge i_clk_sys) // R17
		disable iff (i_sys_rst) i_ce && wr_st |=>
		q.hys_a == $past(i_wdata[1:0]))
		else $error("hysteresis not loaded");
	a_invert_flip: assert property (@(posedge i_clk_sys) // R5
		disable iff (i_sys_rst) i_ce && on_v[0] && $stable(on_v[0])
		&& $stable(raw_s[0]) && $changed(inv_v[0]) |-> toggle[0])
		else $error("polarity flip not seen");
	a_read_status: assert property (@(posedge i_clk_sys) // R7
		disable iff (i_sys_rst) i_ce && i_rd && i_addr == OFS_STATUS
		|=> o_rdata == {$past(q.pending), $past(live)})
		else $error("status read wrong");
	a_on_decode: assert property (@(posedge i_clk_sys) // R1
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_CFG_AB
		|=> on_v[0] == $past(i_wdata[7]))
		else $error("enable bit not decoded");

	// ------------------------------------------------------------
	// checks: register bus
	// ------------------------------------------------------------
	a_flag_clear: assert property (@(posedge i_clk_sys) // R17
		disable iff (i_sys_rst) i_ce && wr_st && !i_wdata[ST_PEND_LO]
		&& !toggle[0] |=> !q.pending[0])
		else $error("flag not cleared by zero write");
	a_flag_keep: assert property (@(posedge i_clk_sys) // R9
		disable iff (i_sys_rst) i_ce && wr_st
		&& i_wdata[ST_PEND_LO + 1] && q.pending[1] |=> q.pending[1])
		else $error("flag lost on one write");
	a_clear_race: assert property (@(posedge i_clk_sys) // R9
		disable iff (i_sys_rst) wr_st && toggle[3] |=> q.pending[3])
		else $error("clear beat a new toggle");
	a_hys_bcd_load: assert property (@(posedge i_clk_sys) // R12
		disable iff (i_sys_rst) i_ce && wr_st |=>
		q.hys_bcd == $past(i_wdata[HYS_BCD_LO +: 2]))
		else $error("shared hysteresis not loaded");
	a_cd_decode: assert property (@(posedge i_clk_sys) // R1
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_CFG_CD
		|=> on_v[3] == $past(i_wdata[F_ON]))
		else $error("channel d enable not decoded");
	a_pick_decode: assert property (@(posedge i_clk_sys) // R3
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_CFG_AB
		|=> pick_v[0] == $past(i_wdata[NIB_W + F_PICK]))
		else $error("channel a pick not decoded");
	a_pick_ext: assert property (@(posedge i_clk_sys) // R4
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_CFG_CD
		|=> pick_v[2] == $past(i_wdata[NIB_W + F_PICK]))
		else $error("channel c pick not decoded");
	a_inv_decode: assert property (@(posedge i_clk_sys) // R5
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_CFG_AB
		|=> inv_v[1] == $past(i_wdata[F_INV]))
		else $error("channel b invert not decoded");
	a_allow_decode: assert property (@(posedge i_clk_sys) // R6
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_CFG_CD
		|=> allow_v[2] == $past(i_wdata[NIB_W + F_IRQ]))
		else $error("channel c irq allow not decoded");
	a_threshold_level_zero_load: assert property (@(posedge i_clk_sys) // R13
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_THRESHOLD_LEVEL_ZERO
		|=> o_threshold_level_zero == $past(i_wdata))
		else $error("threshold zero not loaded");
	a_threshold_level_one_load: assert property (@(posedge i_clk_sys) // R13
		disable iff (i_sys_rst) i_ce && i_wr && i_addr == OFS_THRESHOLD_LEVEL_ONE
		|=> o_threshold_level_one == $past(i_wdata))
		else $error("threshold one not loaded");
	a_rdata_idle: assert property (@(posedge i_clk_sys) // R7
		disable iff (i_sys_rst) i_ce && !i_rd |=> o_rdata == RST_BYTE)
		else $error("read data outside its cycle");

	// ------------------------------------------------------------
	// checks: channels
	// ------------------------------------------------------------
	a_ce_freeze: assert property (@(posedge i_clk_sys) // R9
		disable iff (i_sys_rst) !i_ce |=> $stable(q))
		else $error("state moved while clock enable low");
	a_settle_hold: assert property (@(posedge i_clk_sys) // R2
		disable iff (i_sys_rst) settled[1] && on_v[1] |=> settled[1])
		else $error("settle flag dropped while on");
	a_settle_clear: assert property (@(posedge i_clk_sys) // R2
		disable iff (i_sys_rst) i_ce && !on_v[1] |=> !settled[1])
		else $error("settle flag kept while off");
	a_live_follow: assert property (@(posedge i_clk_sys) // R5
		disable iff (i_sys_rst) i_ce && on_v[1] |=>
		live[1] == ($past(raw_s[1]) ^ $past(inv_v[1])))
		else $error("live output does not follow input");
	a_live_off: assert property (@(posedge i_clk_sys) // R7
		disable iff (i_sys_rst) i_ce && !on_v[3] |=> !live[3])
		else $error("live output not forced low");
	a_off_no_flag: assert property (@(posedge i_clk_sys) // R8
		disable iff (i_sys_rst) i_ce && !on_v[2] && !q.pending[2]
		|=> !q.pending[2])
		else $error("flag set on disabled channel");
	a_edge_fall: assert property (@(posedge i_clk_sys) // R10
		disable iff (i_sys_rst) i_ce && on_v[2] && live[2]
		&& !(raw_s[2] ^ inv_v[2]) |-> toggle[2])
		else $error("falling edge missed");
endmodule

// ### bench/cmp_analog_model.sv
`timescale 1ns/1ps
module cmp_analog_model
	import cmp_ctl_pkg::*;
(
	input wire logic [NCH-1:0] i_on,
	input wire logic [NCH-1:0] i_pick,
	input wire logic [7:0] i_threshold_level_zero,
	input wire logic [7:0] i_threshold_level_one,
	input wire logic [7:0] i_ext,
	input wire logic [31:0] i_level,
	output logic [NCH-1:0] o_raw
);
	logic [7:0] th;
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			th = !i_pick[c] ? i_threshold_level_zero : (c == 0 ? i_threshold_level_one : i_ext);
			o_raw[c] = i_on[c] & (i_level[c*8 +: 8] > th);
		end
	end
endmodule

// ### bench/test_quad_comparator_control.sv
`timescale 1ns/1ps
module test_quad_comparator_control
	import cmp_ctl_pkg::*;
;
	typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic clk = 0, rst = 1, ce = 1, wr_s = 0, rd_s = 0, irq;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00, rdata, threshold_level_zero, threshold_level_one, ext = 8'h10;
	logic [3:0] on, pick, settled, raw;
	logic [31:0] level = 32'h0000_0000;
	hys_t hya, hyb;
	int bad_count = 0, total_checks = 0;
	row_t rows[6] = '{'{OFS_CFG_AB, 8'h5a, 8'h5a},
		'{OFS_CFG_CD, 8'ha5, 8'ha5}, '{OFS_THRESHOLD_LEVEL_ZERO, 8'hff, 8'hff},
		'{OFS_THRESHOLD_LEVEL_ONE, 8'h01, 8'h01}, '{OFS_IRQ_MASK, 8'hff, 8'h0f},
		'{16'ha035, 8'hff, 8'h00}};
	always #2 clk = ~clk;
	quad_comparator_control i_dut (.i_clk_sys(clk), .i_sys_rst(rst),
		.i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
		.i_rd(rd_s), .o_rdata(rdata), .i_cmp_raw(raw), .o_cmp_on(on),
		.o_cmp_thresh_pick(pick), .o_threshold_level_zero(threshold_level_zero),
		.o_threshold_level_one(threshold_level_one), .o_chan_a_hysteresis(hya),
		.o_chan_bcd_hysteresis(hyb), .o_cmp_settled(settled), .o_irq(irq));
	cmp_analog_model i_far (.i_on(on), .i_pick(pick), .i_threshold_level_zero(threshold_level_zero),
		.i_threshold_level_one(threshold_level_one), .i_ext(ext), .i_level(level), .o_raw(raw));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		rd(OFS_STATUS, 8'h00);
		foreach (rows[i]) wr(rows[i].a, rows[i].d);
		foreach (rows[i]) rd(rows[i].a, rows[i].e);
		chk({on, pick}, 8'h69);
		$display("test registers done");
		wr(OFS_CFG_CD, 8'h00);
		wr(OFS_THRESHOLD_LEVEL_ZERO, 8'h40);
		wr(OFS_THRESHOLD_LEVEL_ONE, 8'hc0);
		level <= 32'h0000_2080;
		wr(OFS_CFG_AB, 8'ha0);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 8'h11);
		chk({7'h0, irq}, 8'h01);
		wr(OFS_CFG_AB, 8'he0);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 8'h10);
		wr(OFS_STATUS, 8'he0);
		rd(OFS_STATUS, 8'h00);
		chk({7'h0, irq}, 8'h00);
		wr(OFS_CFG_AB, 8'hf0);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 8'h11);
		wr(OFS_IRQ_MASK, 8'h00);
		chk({7'h0, irq}, 8'h00);
		wr(OFS_STATUS, 8'he0);
		wr(OFS_CFG_AB, 8'h70);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 8'h00);
		wr(OFS_CFG_AB, 8'h0c);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 8'h22);
		$display("test channels done");
		for (int k = 0; k < 4; k++) begin
			wr(OFS_STATUS, {4'hf, k[1:0], k[1:0]});
			chk({2'h0, hya, 2'h0, hyb}, {2'h0, k[1:0], 2'h0, k[1:0]});
		end
		rd(OFS_STATUS, 8'h22);
		$display("test hysteresis done");
		// unused threshold parked at zero before the settle wait
		wr(OFS_THRESHOLD_LEVEL_ONE, 8'h00);
		wr(OFS_CFG_CD, 8'h80);
		repeat (SETTLE_CYC - 1) @(posedge clk);
		#1;
		chk({4'h0, settled}, 8'h02);
		@(posedge clk);
		#1;
		chk({4'h0, settled}, 8'h06);
		$display("test settle done");
		// clock enable low: writes and input changes must not land
		ce <= 1'b0;
		ext <= 8'h30;
		wr(OFS_CFG_AB, 8'h00);
		repeat (4) @(posedge clk);
		#1;
		chk({on, settled}, 8'h66);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		rd(OFS_STATUS, 8'h20);
		$display("test clock enable done");
		// reset in mid-run clears everything
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_STATUS, 8'h00);
		rd(OFS_CFG_CD, 8'h00);
		$display("test reset done");
		stop_test();
	end
endmodule
